// ==== core/wes_regs.svh ====
// Register offsets, field positions, reset values and timing counts of the wake-event block.
// Assumes a 50 MHz system clock and an APB slave port with byte addresses.
`ifndef WES_REGS_SVH
`define WES_REGS_SVH

// ****************************************************************
// Register map
// ****************************************************************
`define WES_ADDR_W 12
`define WES_OFS_PMCTRL 12'h084
`define WES_OFS_IRQ_STS 12'h088
`define WES_OFS_IRQ_MASK 12'h08C

// ****************************************************************
// Field positions of power_mgmt_control
// ****************************************************************
`define WES_BIT_SYSCLK_GATE 18
`define WES_BIT_STS_B 17
`define WES_BIT_STS_A 16
`define WES_BIT_EN_B 15
`define WES_BIT_EN_A 14
`define WES_BIT_MAC_EN 9
`define WES_BIT_BUF_TYPE 6
`define WES_BIT_MAC_STS 5
`define WES_BIT_IND 3
`define WES_BIT_POL 2
`define WES_BIT_PIN_EN 1

// ****************************************************************
// Interrupt status bits and reset values
// ****************************************************************
`define WES_IRQ_W 3
`define WES_IRQ_PORT_A 0
`define WES_IRQ_PORT_B 1
`define WES_IRQ_MAC 2
`define WES_RST_IRQ 3'h0
`define WES_RST_CTRL 10'h000

// ****************************************************************
// Timing
// ****************************************************************
`define WES_CLK_KHZ 50000
`define WES_PULSE_MS 50
`define WES_PULSE_CYCLES (`WES_PULSE_MS * `WES_CLK_KHZ)
`define WES_CNT_W 22

`endif

// ==== core/wes_pkg.sv ====
// Types shared by the wake-event signalling block.
// Assumes wes_regs.svh is compiled with it.
package wes_pkg;

    // ****************************************************************
    // Stored control and status fields
    // ****************************************************************
    typedef struct packed {
        logic sysclk_gate;
        logic sts_b;
        logic sts_a;
        logic en_b;
        logic en_a;
        logic mac_en;
        logic buf_type;
        logic mac_sts;
        logic ind;
        logic pol;
        logic pin_en;
    } wes_ctrl_t;

    // Wake pin sequencing states.
    typedef enum logic [3:0] {
        WES_PIN_IDLE = 4'b0001,
        WES_PIN_STATIC = 4'b0010,
        WES_PIN_PULSE = 4'b0100,
        WES_PIN_SPENT = 4'b1000
    } wes_pin_state_t;

endpackage

// ==== core/wes_top.sv ====
// Wake-event signalling: power_mgmt_control bits 1 to 18, sticky wake flags, interrupt and wake pin.
// Assumes event inputs come from logic on clk and stay high until their source is cleared.
//
// Functional notes
// (R1) Gate bit high stops the MAC 25/100 MHz system clocks, RX/TX clocks keep running.
// (R2) Gate bit sets only on the second consecutive one-write; a zero-write clears and rearms.
// (R3) Port wake flags set from PHY events; software clear works only once the event is gone.
// (R4) Enabled port flags raise the wake interrupt request.
// (R5) Enabled port flags also drive the wake pin if pin enable is set.
// (R6) MAC wake enable routes the MAC flag to interrupt request and to the pin.
// (R7) MAC wake flag sets on MAC wake frames; clear works only once the event is gone.
// (R8) Buffer type zero gives open-drain, one gives push-pull.
// (R9) Open-drain pin ignores polarity and is always active low.
// (R10) Indication one gives a 50 ms pulse per event, zero drives the pin steadily.
// (R11) Clearing flags or enables releases an active pin.
// (R12) Polarity one makes push-pull pin active high, zero active low; resets to zero.
// (R13) Reserved bits read zero, ignore writes and steer nothing.
// (R14) Pin enable zero keeps the pin inactive without touching the interrupt request.
// (R15) Pulse width is a system clock counter derived from the clock rate.
`include "wes_regs.svh"

module wes_top #(
    parameter int PULSE_CYCLES = `WES_PULSE_CYCLES
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`WES_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic port_a_event,
    input wire logic port_b_event,
    input wire logic mac_wake_event,
    output logic mac_sysclk_gate,
    output logic wake_interrupt_request,
    output logic wake_event_pin_out,
    output logic wake_event_pin_oe,
    output logic irq
);

    // ****************************************************************
    // APB decode
    // ****************************************************************
    wes_pkg::wes_ctrl_t ctrl_q, ctrl_d;
    logic gate_armed_q, gate_armed_d;
    logic [`WES_IRQ_W-1:0] irq_sts_q, irq_sts_d, irq_mask_q, irq_mask_d;
    logic [31:0] prdata_q, rd_mux;
    logic [31:0] ctrl_rd;
    logic irq_q;

    // Address match, shared by read mux, write strobes and error answer.
    function automatic logic addr_is(input logic [`WES_ADDR_W-1:0] a, input logic [`WES_ADDR_W-1:0] ofs);
        addr_is = (a[`WES_ADDR_W-1:2] == ofs[`WES_ADDR_W-1:2]);
    endfunction

    // Access phase completes in its first cycle unless the block is frozen.
    wire setup_ph = psel & ~penable;
    wire access_ph = psel & penable;
    wire hit_ctrl = addr_is(paddr, `WES_OFS_PMCTRL);
    wire hit_sts = addr_is(paddr, `WES_OFS_IRQ_STS);
    wire hit_mask = addr_is(paddr, `WES_OFS_IRQ_MASK);
    wire hit_any = hit_ctrl | hit_sts | hit_mask;
    wire wr_go = access_ph & pwrite & ce;
    wire wr_ctrl = wr_go & hit_ctrl;
    wire wr_sts = wr_go & hit_sts;
    wire wr_mask = wr_go & hit_mask;
    // Byte lanes 0..2 hold every writable bit; a lane left out keeps its bits.
    wire [31:0] lane = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
    wire [31:0] wmask = lane & pwdata;
    wire [31:0] wsel = lane;

    assign pready = ce;
    assign pslverr = access_ph & ~hit_any;
    assign prdata = prdata_q;

    // Reserved and excluded positions are tied to zero here. [R13]
    assign ctrl_rd = {13'h0000, ctrl_q.sysclk_gate, ctrl_q.sts_b, ctrl_q.sts_a, ctrl_q.en_b, ctrl_q.en_a,
                      4'h0, ctrl_q.mac_en, 2'h0, ctrl_q.buf_type, ctrl_q.mac_sts, 1'b0,
                      ctrl_q.ind, ctrl_q.pol, ctrl_q.pin_en, 1'b0};
    assign rd_mux = hit_ctrl ? ctrl_rd :
                    hit_sts ? {29'h00000000, irq_sts_q} :
                    hit_mask ? {29'h00000000, irq_mask_q} : 32'h00000000;

    // Read data is captured in the setup cycle so the access phase sees a stable flop value.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            prdata_q <= 32'h00000000;
        end else if (ce && setup_ph && !pwrite) begin
            prdata_q <= rd_mux;
        end
    end

    // ****************************************************************
    // Control register next state
    // ****************************************************************
    wire wr_gate = wr_ctrl & wsel[`WES_BIT_SYSCLK_GATE];
    wire wr_gate_one = wr_gate & pwdata[`WES_BIT_SYSCLK_GATE];
    wire clr_b = wr_ctrl & wmask[`WES_BIT_STS_B];
    wire clr_a = wr_ctrl & wmask[`WES_BIT_STS_A];
    wire clr_mac = wr_ctrl & wmask[`WES_BIT_MAC_STS];

    // Fields written only where their lane is selected; reserved bits are never looked at. [R13]
    function automatic logic fld(input logic old, input int pos);
        fld = wsel[pos] ? pwdata[pos] : old;
    endfunction

    always_comb begin
        ctrl_d = ctrl_q;
        gate_armed_d = gate_armed_q;
        // First one-write arms, second sets; a zero-write clears both. [R2]
        if (wr_gate) begin
            if (!wr_gate_one) begin
                ctrl_d.sysclk_gate = 1'b0;
                gate_armed_d = 1'b0;
            end else if (gate_armed_q) begin
                ctrl_d.sysclk_gate = 1'b1;
            end else begin
                gate_armed_d = 1'b1;
            end
        end
        // A live event wins over the clear, so a flag only drops once its source has. [R3] [R7]
        ctrl_d.sts_b = port_b_event | (ctrl_q.sts_b & ~clr_b);
        ctrl_d.sts_a = port_a_event | (ctrl_q.sts_a & ~clr_a);
        ctrl_d.mac_sts = mac_wake_event | (ctrl_q.mac_sts & ~clr_mac);
        if (wr_ctrl) begin
            ctrl_d.en_b = fld(ctrl_q.en_b, `WES_BIT_EN_B);
            ctrl_d.en_a = fld(ctrl_q.en_a, `WES_BIT_EN_A);
            ctrl_d.mac_en = fld(ctrl_q.mac_en, `WES_BIT_MAC_EN);
            ctrl_d.buf_type = fld(ctrl_q.buf_type, `WES_BIT_BUF_TYPE);
            ctrl_d.ind = fld(ctrl_q.ind, `WES_BIT_IND);
            ctrl_d.pol = fld(ctrl_q.pol, `WES_BIT_POL);
            ctrl_d.pin_en = fld(ctrl_q.pin_en, `WES_BIT_PIN_EN);
        end
    end

    // Polarity and all enables come out of reset at zero. [R12]
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_q <= wes_pkg::wes_ctrl_t'(11'h000);
            gate_armed_q <= 1'b0;
        end else if (ce) begin
            ctrl_q <= ctrl_d;
            gate_armed_q <= gate_armed_d;
        end
    end

    // The MAC clock controller stops only the 25/100 MHz system clocks on this level. [R1]
    assign mac_sysclk_gate = ctrl_q.sysclk_gate;

    // ****************************************************************
    // Wake sources and interrupt request
    // ****************************************************************
    wire [2:0] wake_terms = {ctrl_q.mac_sts & ctrl_q.mac_en, ctrl_q.sts_b & ctrl_q.en_b, ctrl_q.sts_a & ctrl_q.en_a};
    logic [2:0] wake_terms_q;
    wire [2:0] new_terms = wake_terms & ~wake_terms_q;
    wire new_evt = |new_terms;

    // Request ignores pin enable, so a disabled pin never hides the interrupt. [R4] [R6] [R14]
    assign wake_interrupt_request = |wake_terms;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wake_terms_q <= 3'h0;
        end else if (ce) begin
            wake_terms_q <= wake_terms;
        end
    end

    // ****************************************************************
    // Interrupt status and mask
    // ****************************************************************
    always_comb begin
        irq_sts_d = irq_sts_q;
        irq_mask_d = irq_mask_q;
        if (wr_sts) begin
            irq_sts_d = irq_sts_q & ~wmask[`WES_IRQ_W-1:0];
        end
        // Setting after the clear keeps an event that lands on the clearing write.
        irq_sts_d[`WES_IRQ_PORT_A] = irq_sts_d[`WES_IRQ_PORT_A] | new_terms[0];
        irq_sts_d[`WES_IRQ_PORT_B] = irq_sts_d[`WES_IRQ_PORT_B] | new_terms[1];
        irq_sts_d[`WES_IRQ_MAC] = irq_sts_d[`WES_IRQ_MAC] | new_terms[2];
        if (wr_mask && pstrb[0]) begin
            irq_mask_d = pwdata[`WES_IRQ_W-1:0];
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_sts_q <= `WES_RST_IRQ;
            irq_mask_q <= `WES_RST_IRQ;
            irq_q <= 1'b0;
        end else if (ce) begin
            irq_sts_q <= irq_sts_d;
            irq_mask_q <= irq_mask_d;
            irq_q <= |(irq_sts_d & irq_mask_d);
        end
    end
    assign irq = irq_q;

    // ****************************************************************
    // Wake pin sequencer
    // ****************************************************************
    localparam logic [`WES_CNT_W-1:0] PULSE_LOAD = `WES_CNT_W'(PULSE_CYCLES);
    wes_pkg::wes_pin_state_t pin_st_q, pin_st_d;
    logic [`WES_CNT_W-1:0] cnt_q, cnt_d;
    logic pin_out_q, pin_oe_q;

    // Pin enable gates only the pin path. [R5] [R6] [R14]
    wire pin_src = ctrl_q.pin_en & (|wake_terms);
    wire cnt_last = (cnt_q == `WES_CNT_W'(1));

    always_comb begin
        pin_st_d = pin_st_q;
        cnt_d = cnt_q;
        case (pin_st_q)
            wes_pkg::WES_PIN_IDLE: begin
                if (pin_src) begin
                    pin_st_d = ctrl_q.ind ? wes_pkg::WES_PIN_PULSE : wes_pkg::WES_PIN_STATIC;
                    cnt_d = PULSE_LOAD;
                end
            end
            wes_pkg::WES_PIN_STATIC: begin
                if (!pin_src) begin
                    pin_st_d = wes_pkg::WES_PIN_IDLE;
                end else if (ctrl_q.ind && new_evt) begin
                    pin_st_d = wes_pkg::WES_PIN_PULSE;
                    cnt_d = PULSE_LOAD;
                end
            end
            wes_pkg::WES_PIN_PULSE: begin
                // Each fresh event restarts the full pulse width. [R10] [R15]
                if (!pin_src) begin
                    pin_st_d = wes_pkg::WES_PIN_IDLE;
                end else if (!ctrl_q.ind) begin
                    pin_st_d = wes_pkg::WES_PIN_STATIC;
                end else if (new_evt) begin
                    cnt_d = PULSE_LOAD;
                end else if (cnt_last) begin
                    pin_st_d = wes_pkg::WES_PIN_SPENT;
                end else begin
                    cnt_d = cnt_q - `WES_CNT_W'(1);
                end
            end
            wes_pkg::WES_PIN_SPENT: begin
                // Pulse has run out but the flags stand; wait for a new event or a clear. [R11]
                if (!pin_src) begin
                    pin_st_d = wes_pkg::WES_PIN_IDLE;
                end else if (!ctrl_q.ind) begin
                    pin_st_d = wes_pkg::WES_PIN_STATIC;
                end else if (new_evt) begin
                    pin_st_d = wes_pkg::WES_PIN_PULSE;
                    cnt_d = PULSE_LOAD;
                end
            end
            default: begin
                pin_st_d = wes_pkg::WES_PIN_IDLE;
            end
        endcase
    end

    wire pin_act_d = (pin_st_d == wes_pkg::WES_PIN_STATIC) | (pin_st_d == wes_pkg::WES_PIN_PULSE);
    // Open-drain only pulls low, so polarity has no meaning there. [R8] [R9] [R12]
    wire pin_oe_d = ctrl_q.buf_type | pin_act_d;
    wire pin_out_d = ctrl_q.buf_type & (ctrl_q.pol ? pin_act_d : ~pin_act_d);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pin_st_q <= wes_pkg::WES_PIN_IDLE;
            cnt_q <= `WES_CNT_W'(0);
            pin_out_q <= 1'b0;
            pin_oe_q <= 1'b0;
        end else if (ce) begin
            pin_st_q <= pin_st_d;
            cnt_q <= cnt_d;
            pin_out_q <= pin_out_d;
            pin_oe_q <= pin_oe_d;
        end
    end
    assign wake_event_pin_out = pin_out_q;
    assign wake_event_pin_oe = pin_oe_q;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    sequence s_first_one;
        wr_gate_one && !gate_armed_q && !ctrl_q.sysclk_gate;
    endsequence
    sequence s_second_one;
        wr_gate_one && gate_armed_q;
    endsequence

    AST_GATE_FIRST_WRITE_HOLDS: assert property (s_first_one |=> !ctrl_q.sysclk_gate && gate_armed_q) // [R2]
        else $error("gate bit set on a single one-write");
    AST_GATE_ZERO_CLEARS: assert property (wr_gate && !wr_gate_one |=> !mac_sysclk_gate && !gate_armed_q) // [R2]
        else $error("zero-write left gate or count set");
    AST_GATE_SECOND_SETS: assert property (s_first_one ##[1:1000] s_second_one |=> mac_sysclk_gate) // [R1] [R2]
        else $error("gate did not set after two one-writes");
    AST_STS_FOLLOWS_EVENT: assert property (ce && port_a_event |=> ctrl_q.sts_a) // [R3]
        else $error("port A flag missed its event");
    AST_STS_CLEAR_BLOCKED: assert property (ce && port_b_event && clr_b |=> ctrl_q.sts_b) // [R3]
        else $error("port B flag cleared while event still present");
    AST_MAC_STS_CLEARS: assert property (ce && clr_mac && !mac_wake_event |=> !ctrl_q.mac_sts) // [R7]
        else $error("MAC flag did not clear after event gone");
    AST_REQ_IGNORES_PIN_EN: assert property (ctrl_q.sts_a && ctrl_q.en_a |-> wake_interrupt_request) // [R4] [R14]
        else $error("interrupt request missing for enabled port flag");
    AST_PIN_DISABLED_IDLE: assert property (ce && !ctrl_q.pin_en |=> pin_st_q == wes_pkg::WES_PIN_IDLE) // [R14]
        else $error("pin sequencer active with pin disabled");
    AST_RELEASE_ON_CLEAR: assert property (ce && !(|wake_terms) && !ctrl_q.buf_type |=> !wake_event_pin_oe) // [R11]
        else $error("open-drain pin still pulled after sources cleared");
    AST_OD_ACTIVE_LOW: assert property (wake_event_pin_oe && !$past(ctrl_q.buf_type) |-> !wake_event_pin_out) // [R9]
        else $error("open-drain pin driven high");
    AST_PP_POLARITY: assert property ($past(ce) && $past(ctrl_q.buf_type) && $past(pin_act_d)
                                      |-> wake_event_pin_oe && wake_event_pin_out == $past(ctrl_q.pol)) // [R8] [R12]
        else $error("push-pull pin level does not match polarity");
    AST_PULSE_LOADS_FULL: assert property (ce && pin_st_q != wes_pkg::WES_PIN_PULSE
                                           && pin_st_d == wes_pkg::WES_PIN_PULSE |=> cnt_q == PULSE_LOAD) // [R10] [R15]
        else $error("pulse did not start with the full width");
    AST_PULSE_BOUNDED: assert property (cnt_q <= PULSE_LOAD) // [R15]
        else $error("pulse counter beyond pulse width");
    AST_RESERVED_ZERO: assert property (ctrl_rd[13:10] == 4'h0 && ctrl_rd[8:7] == 2'h0 && !ctrl_rd[4]) // [R13]
        else $error("reserved control bits read non-zero");

    // The pin flops lag their cause by one edge, so buffer type and polarity are taken one edge back.
    AST_PP_RELEASE: assert property (ce && !(|wake_terms) && ctrl_q.buf_type
                                     |=> wake_event_pin_oe && wake_event_pin_out == !$past(ctrl_q.pol)) // [R11] [R12]
        else $error("push-pull pin not at its inactive level after sources cleared");
    AST_PULSE_ENDS: assert property (ce && pin_st_q == wes_pkg::WES_PIN_PULSE && cnt_last && !new_evt && pin_src
                                     && ctrl_q.ind |=> pin_st_q == wes_pkg::WES_PIN_SPENT) // [R10]
        else $error("pulse did not end at the terminal count");

    // A fresh enabled port A term with its mask bit set must raise the interrupt one edge later.
    AST_IRQ_RAISED: assert property (ce && new_terms[0] && irq_mask_d[0] |=> irq) // [R4]
        else $error("interrupt output missed an unmasked port A event");

endmodule

// ==== tb/test_wake_event_signalling.sv ====
// Self-checking bench for the wake-event block: registers over APB, wake flags, interrupt and wake pin.
// Assumes the core files are compiled first and that wes_regs.svh is on the include path.
`include "wes_regs.svh"

module test_wake_event_signalling;
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************************************
    // Signals and instance
    // ****************************************************************
    // A short pulse keeps the run brief; expectations follow from it.
    localparam int PULSE = 20;
    localparam logic [11:0] CTRL = `WES_OFS_PMCTRL;
    localparam logic [11:0] ISTS = `WES_OFS_IRQ_STS;
    localparam logic [11:0] IMSK = `WES_OFS_IRQ_MASK;
    logic clk, arst_n, psel, penable, pwrite, pready, pslverr;
    logic ev_a, ev_b, ev_mac, gate, req, pin_out, pin_oe, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic err;
    int n_mismatch, n_compared, cyc, k;

    wes_top #(.PULSE_CYCLES(PULSE)) DUT (.clk(clk), .arst_n(arst_n), .ce(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .port_a_event(ev_a),
        .port_b_event(ev_b), .mac_wake_event(ev_mac), .mac_sysclk_gate(gate),
        .wake_interrupt_request(req), .wake_event_pin_out(pin_out), .wake_event_pin_oe(pin_oe),
        .irq(irq));

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    // Compares with case equality so that an unknown never passes.
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // One APB transfer; the request is held until pready is seen high at an edge.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(rd, exp);
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask

    task automatic print_verdict;
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    // Reset values, then an all-ones write: reserved places stay zero, one gate write is not enough.
    task automatic sc_reset_reserved;
        rchk(CTRL, 32'h0000_0000);
        chk({gate, req, pin_oe, irq}, 4'h0);
        apb(1'b1, CTRL, 32'hFFFF_FFFF);
        rchk(CTRL, 32'h0000_C24E);
        chk(gate, 1'b0);
        apb(1'b1, CTRL, 32'h0000_0000);
    endtask

    // The gate needs two consecutive one-writes; a zero-write clears and restarts the count.
    task automatic sc_gate;
        apb(1'b1, CTRL, 32'h0004_0000);
        rchk(CTRL, 32'h0000_0000);
        apb(1'b1, CTRL, 32'h0004_0000);
        rchk(CTRL, 32'h0004_0000);
        chk(gate, 1'b1);
        apb(1'b1, CTRL, 32'h0000_0000);
        wait_cyc(0);
        chk(gate, 1'b0);
        apb(1'b1, CTRL, 32'h0004_0000);
        wait_cyc(0);
        chk(gate, 1'b0);
        apb(1'b1, CTRL, 32'h0000_0000);
    endtask

    // Port A, open drain, static: pin enable gates only the pin; clear fails while the event stays.
    task automatic sc_port_a;
        apb(1'b1, IMSK, 32'h0000_0007);
        apb(1'b1, CTRL, 32'h0000_4000);
        ev_a <= 1'b1;
        wait_cyc(3);
        chk({req, pin_oe}, 2'b10);
        rchk(ISTS, 32'h0000_0001);
        chk(irq, 1'b1);
        apb(1'b1, CTRL, 32'h0000_4006);
        wait_cyc(2);
        chk({pin_oe, pin_out}, 2'b10);
        apb(1'b1, CTRL, 32'h0001_4006);
        rchk(CTRL, 32'h0001_4006);
        apb(1'b1, CTRL, 32'h0000_0006);
        wait_cyc(2);
        chk({req, pin_oe}, 2'b00);
        @(posedge clk);
        ev_a <= 1'b0;
        apb(1'b1, CTRL, 32'h0001_0006);
        rchk(CTRL, 32'h0000_0006);
        apb(1'b1, ISTS, 32'h0000_0007);
        wait_cyc(2);
        chk(irq, 1'b0);
    endtask

    // Port B, push-pull, active high, pulsed: the pin is active for one pulse only.
    task automatic sc_port_b_pulse;
        apb(1'b1, CTRL, 32'h0000_804E);
        ev_b <= 1'b1;
        k = 0;
        repeat (3 * PULSE) begin
            @(negedge clk);
            if (pin_out === 1'b1) k++;
        end
        chk(k, PULSE);
        chk({pin_oe, req}, 2'b11);
        rchk(CTRL, 32'h0002_804E);
        ev_b <= 1'b0;
        apb(1'b1, CTRL, 32'h0002_804E);
        wait_cyc(2);
        chk({req, pin_out}, 2'b00);
        apb(1'b1, ISTS, 32'h0000_0007);
    endtask

    // MAC wake, push-pull, active low, static; release by clearing the flag.
    task automatic sc_mac;
        apb(1'b1, CTRL, 32'h0000_0242);
        ev_mac <= 1'b1;
        wait_cyc(3);
        chk({req, pin_oe, pin_out}, 3'b110);
        rchk(CTRL, 32'h0000_0262);
        rchk(ISTS, 32'h0000_0004);
        wait_cyc(2 * PULSE);
        chk(pin_out, 1'b0);
        @(posedge clk);
        ev_mac <= 1'b0;
        apb(1'b1, CTRL, 32'h0000_0262);
        wait_cyc(2);
        chk({req, pin_out}, 2'b01);
        apb(1'b1, ISTS, 32'h0000_0007);
    endtask

    // An unmapped address answers with an error and reads zero.
    task automatic sc_unmapped;
        apb(1'b1, 12'h0F0, 32'hFFFF_FFFF);
        chk(err, 1'b1);
        apb(1'b0, 12'h0F0, 32'h0000_0000);
        chk({err, rd}, {1'b1, 32'h0000_0000});
        rchk(CTRL, 32'h0000_0242);
    endtask

    // ****************************************************************
    // Clock, timeout and main sequence
    // ****************************************************************
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // The whole run needs well under a thousand cycles; the ceiling leaves ample margin.
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            print_verdict();
        end
    end

    initial begin
        {arst_n, psel, penable, pwrite, ev_a, ev_b, ev_mac} = 7'h00;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        sc_reset_reserved();
        sc_gate();
        sc_port_a();
        sc_port_b_pulse();
        sc_mac();
        sc_unmapped();
        print_verdict();
    end
endmodule
